// [touch_adc_conversion_control.sv]
// conversion control for a four-wire resistive touch controller
// assumes register port already decoded from the serial slave and comparator synchronous
`timescale 1ns/100ps
`include "touch_adc_map.svh"

module touch_adc_conversion_control (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// register port
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wr_data,
	output logic [15:0] reg_rd_data,
	// panel and converter front end
	input wire logic pen_touch_in,
	input wire logic cmp_high,
	output logic [3:0] mux_sel,
	output logic drivers_on,
	output logic sample_hold,
	output logic [11:0] sar_code,
	// status and interrupt
	output logic result_available,
	output logic pen_touch_irq,
	output logic touch_or_result_irq_pin
);
	import touch_adc_pkg::*;

	// ==========================================
	// state and decoded fields
	touch_adc_pkg::ctrl_state_t s_r; // registered state
	touch_adc_pkg::ctrl_state_t s_nxt; // next state
	logic conv_tick; // conversion clock tick
	logic div_restart; // realign divider at conversion start
	logic res12; // twelve-bit resolution selected
	logic [1:0] clk_div; // conversion clock divide field
	logic [2:0] stab_code; // stabilization delay code
	logic [1:0] mode; // touch mode
	logic [3:0] func; // converter function select
	logic pint_dav; // irq pin shows result available
	logic cmd_wr; // command register written
	logic [1:0] cmd; // command code
	logic start_seq; // begin a settled sequence
	logic start_direct; // begin a host-controlled conversion
	logic [3:0] first_chan; // first channel of a request
	logic res_read; // a result register is read

	// ==========================================
	// conversion clock divider
	conv_clock_divider u_div (
		.sys_clk(sys_clk),
		.reset(reset),
		.divide(clk_div),
		.restart(div_restart),
		.tick(conv_tick)
	);

	// ==========================================
	// field decode of configuration register zero
	always_comb begin
		res12 = s_r.cfg0[`CFG0_RES12_BIT];
		clk_div = s_r.cfg0[`CFG0_CLKDIV_LSB +: 2];
		stab_code = s_r.cfg0[`CFG0_STAB_LSB +: 3];
		mode = s_r.cfg0[`CFG0_MODE_LSB +: 2];
		func = s_r.cfg0[`CFG0_FUNC_LSB +: 4];
		pint_dav = s_r.cfg0[`CFG0_PINT_BIT];
		cmd_wr = reg_wr_en && (reg_addr == `ADDR_CMD);
		cmd = reg_wr_data[1:0];
		res_read = reg_rd_en && (reg_addr >= `ADDR_RES_BASE) && (reg_addr <= `ADDR_RES_LAST);
		// function zero is the full triplet and cross-panel scan
		if (func == 4'h0) begin
			first_chan = 4'h0;
		end else if (func <= 4'h9) begin
			first_chan = func - 4'h1;
		end else begin
			first_chan = `AUX_CHAN;
		end
	end

	// ==========================================
	// start conditions per touch mode
	always_comb begin
		start_seq = 1'b0;
		start_direct = 1'b0;
		if (s_r.state == ST_IDLE) begin
			if (mode == `MODE_SELF) begin
				start_seq = pen_touch_in;
			end else if (mode == `MODE_HOST_INIT) begin
				start_seq = cmd_wr && (cmd == `CMD_CONVERT);
			end else begin
				start_direct = cmd_wr && (cmd == `CMD_CONVERT);
			end
		end
		div_restart = (s_r.state == ST_SAMPLE) && (s_r.samp_cnt == 3'h1);
	end

	// ==========================================
	// next-state logic: registers, sequencer, flags
	always_comb begin
		s_nxt = s_r;
		// register writes
		if (reg_wr_en && (reg_addr == `ADDR_CFG0)) begin
			s_nxt.cfg0 = reg_wr_data;
		end
		// register reads, answered one cycle later
		if (reg_rd_en) begin
			if (reg_addr == `ADDR_CFG0) begin
				s_nxt.rd_data = s_r.cfg0;
				s_nxt.rd_data[`CFG0_IDLE_BIT] = (s_r.state == ST_IDLE);
			end else if (reg_addr == `ADDR_CMD) begin
				s_nxt.rd_data = {14'h0000, s_r.hold_drv, s_r.state != ST_IDLE};
			end else if (res_read) begin
				s_nxt.rd_data = {4'h0, s_r.res[reg_addr - `ADDR_RES_BASE]};
			end else begin
				s_nxt.rd_data = 16'h0000;
			end
		end
		// reading a result clears data available
		if (res_read) begin
			s_nxt.avail = 1'b0;
		end
		// sequencer
		case (s_r.state)
			ST_IDLE: begin
				if (cmd_wr && (cmd == `CMD_DRIVERS)) begin
					s_nxt.hold_drv = 1'b1;
				end
				if (start_seq) begin
					s_nxt.state = ST_STAB;
					s_nxt.chan = first_chan;
					s_nxt.scan_all = (func == 4'h0);
					s_nxt.stab_cnt = {stab_code, `STAB_FILL};
				end else if (start_direct) begin
					// host has already settled the panel
					s_nxt.state = ST_SAMPLE;
					s_nxt.chan = first_chan;
					s_nxt.scan_all = 1'b0;
					s_nxt.samp_cnt = `SAMPLE_CYCLES;
				end
			end
			ST_STAB: begin
				// drivers are on, wait for the panel to settle
				if (s_r.stab_cnt == 8'h00) begin
					s_nxt.state = ST_SAMPLE;
					s_nxt.samp_cnt = `SAMPLE_CYCLES;
				end else begin
					s_nxt.stab_cnt = s_r.stab_cnt - 8'h01;
				end
			end
			ST_SAMPLE: begin
				// track then hold on the sampling capacitor
				if (s_r.samp_cnt == 3'h1) begin
					s_nxt.state = ST_CONV;
					s_nxt.bit_idx = res12 ? `MSB_12 : `MSB_10;
					s_nxt.sar = 12'h000;
					s_nxt.sar[res12 ? `MSB_12 : `MSB_10] = 1'b1;
				end else begin
					s_nxt.samp_cnt = s_r.samp_cnt - 3'h1;
				end
			end
			ST_CONV: begin
				// one bit decided per conversion clock
				if (conv_tick) begin
					if (!cmp_high) begin
						s_nxt.sar[s_r.bit_idx] = 1'b0;
					end
					if (s_r.bit_idx == 4'h0) begin
						s_nxt.state = ST_STORE;
					end else begin
						s_nxt.bit_idx = s_r.bit_idx - 4'h1;
						s_nxt.sar[s_r.bit_idx - 4'h1] = 1'b1;
					end
				end
			end
			ST_STORE: begin
				s_nxt.res[s_r.chan] = s_r.sar;
				s_nxt.avail = 1'b1;
				if (s_r.scan_all && (s_r.chan < `LAST_SCAN_CHAN)) begin
					// next triplet or cross-panel channel
					s_nxt.chan = s_r.chan + 4'h1;
					s_nxt.state = ST_STAB;
					s_nxt.stab_cnt = {stab_code, `STAB_FILL};
				end else begin
					s_nxt.state = ST_IDLE;
				end
			end
			default: begin
				s_nxt.state = ST_IDLE;
			end
		endcase
		// stop aborts any sequence and releases the drivers
		if (cmd_wr && (cmd == `CMD_STOP)) begin
			s_nxt.state = ST_IDLE;
			s_nxt.hold_drv = 1'b0;
		end
		// registered outputs
		s_nxt.drv = (s_nxt.state != ST_IDLE) || s_nxt.hold_drv;
		s_nxt.shold = (s_nxt.state == ST_SAMPLE);
		s_nxt.pen_irq = pen_touch_in;
		s_nxt.pin = pint_dav ? s_nxt.avail : pen_touch_in;
	end

	// ==========================================
	// state register
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s_r <= '0;
			s_r.state <= ST_IDLE;
			s_r.cfg0 <= `CFG0_WRITE_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================
	// outputs straight from flip-flops
	assign reg_rd_data = s_r.rd_data;
	assign mux_sel = s_r.chan;
	assign drivers_on = s_r.drv;
	assign sample_hold = s_r.shold;
	assign sar_code = s_r.sar;
	assign result_available = s_r.avail;
	assign pen_touch_irq = s_r.pen_irq;
	assign touch_or_result_irq_pin = s_r.pin;

	// ==========================================
	// assertions
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	// conversion starts only when the settle counter is empty
	stab_zero_a: assert property (
		(s_r.state == ST_STAB && s_nxt.state == ST_SAMPLE) |-> s_r.stab_cnt == 8'h00)
		else $error("conversion began before settle count ended");

	// bit index stays within the chosen width
	res_width_a: assert property (
		(s_r.state == ST_CONV) |-> (s_r.bit_idx <= (res12 ? `MSB_12 : `MSB_10)))
		else $error("bit index beyond selected resolution");

	// ten-bit result has clear upper bits
	ten_bit_a: assert property (
		(s_r.state == ST_STORE && !res12) |-> s_r.sar[11:10] == 2'b00)
		else $error("ten-bit result wider than ten bits");

	// divide zero ticks every cycle
	div_zero_a: assert property (
		(clk_div == 2'h0) |-> conv_tick)
		else $error("undivided conversion clock missed a cycle");

	// store raises data available next cycle
	store_avail_a: assert property (
		(s_r.state == ST_STORE) |=> result_available)
		else $error("data available not raised after store");

	// stored result matches the finished code
	result_write_a: assert property (
		(s_r.state == ST_STORE) |=> s_r.res[$past(s_r.chan)] == $past(s_r.sar))
		else $error("result register not written");

	// pen irq follows the touch one cycle later
	pen_irq_a: assert property (
		pen_touch_in |=> pen_touch_irq)
		else $error("pen-touch irq missed a touch");

	// self-initiated mode reacts to a touch
	self_start_a: assert property (
		(s_r.state == ST_IDLE && mode == `MODE_SELF && pen_touch_in
			&& !(cmd_wr && cmd == `CMD_STOP)) |=> s_r.state == ST_STAB)
		else $error("touch did not start a sequence");

	// config zero idle bit reflects idle state
	cfg_read_a: assert property (
		(reg_rd_en && reg_addr == `ADDR_CFG0)
			|=> reg_rd_data[`CFG0_IDLE_BIT] == ($past(s_r.state) == ST_IDLE))
		else $error("config read idle bit wrong");

	// drivers stay on through sampling and converting
	drivers_a: assert property (
		(s_r.state == ST_SAMPLE || s_r.state == ST_CONV) |-> drivers_on)
		else $error("drivers off during conversion");

	// stop ends any sequence and drops the held drivers
	stop_abort_a: assert property (
		(cmd_wr && cmd == `CMD_STOP) |=> (s_r.state == ST_IDLE && !s_r.hold_drv))
		else $error("stop command did not end the sequence");

	// drivers-only command turns the panel drivers on
	drivers_hold_a: assert property (
		(s_r.state == ST_IDLE && cmd_wr && cmd == `CMD_DRIVERS) |=> drivers_on)
		else $error("drivers-only command left drivers off");

	// idle with no hold keeps the panel drivers off
	drivers_idle_a: assert property (
		(s_r.state == ST_IDLE && !s_r.hold_drv) |-> !drivers_on)
		else $error("drivers on while idle");

	// host-initiated mode settles and sequences on a convert command
	host_start_a: assert property (
		(s_r.state == ST_IDLE && mode == `MODE_HOST_INIT && cmd_wr && cmd == `CMD_CONVERT)
			|=> s_r.state == ST_STAB)
		else $error("convert did not start a settled sequence");

	// host-controlled mode samples at once on a convert command
	direct_start_a: assert property (
		(s_r.state == ST_IDLE && (mode == `MODE_HOST_CTRL || mode == 2'h0)
			&& cmd_wr && cmd == `CMD_CONVERT) |=> s_r.state == ST_SAMPLE)
		else $error("convert did not start sampling");

	// settling continues while the counter is not empty
	stab_wait_a: assert property (
		(s_r.state == ST_STAB && s_r.stab_cnt != 8'h00 && !(cmd_wr && cmd == `CMD_STOP))
			|=> s_r.state == ST_STAB)
		else $error("settling ended early");

	// sample and hold tracks in the sampling state
	sample_hold_a: assert property (
		(s_r.state == ST_SAMPLE) |-> sample_hold)
		else $error("sample and hold not tracking");

	// channel select stays put while bits are decided
	mux_hold_a: assert property (
		(s_r.state == ST_CONV) |=> $stable(mux_sel))
		else $error("channel changed during conversion");

	// a bit is decided only on a conversion clock tick
	tick_step_a: assert property (
		(s_r.state == ST_CONV && !conv_tick) |=> $stable(s_r.bit_idx))
		else $error("bit decided without a conversion tick");

	// result reads carry zeros above the twelve result bits
	res_upper_a: assert property (
		res_read |=> reg_rd_data[15:12] == 4'h0)
		else $error("result read has upper bits set");

	// reading a result clears data available unless a store coincides
	read_clear_a: assert property (
		(res_read && s_r.state != ST_STORE) |=> !result_available)
		else $error("result read left data available set");

	// irq pin shows data available when so selected
	pin_dav_a: assert property (
		pint_dav |=> touch_or_result_irq_pin == result_available)
		else $error("irq pin does not show data available");

	// irq pin shows pen touch otherwise
	pin_pen_a: assert property (
		!pint_dav |=> touch_or_result_irq_pin == $past(pen_touch_in))
		else $error("irq pin does not show pen touch");

endmodule

// [touch_adc_map.svh]
// offsets, field positions, reset values and counts for the touch adc control block
// assumes a single oscillator clock and a decoded register port in front of it
//
// Operation
// - resolution programmable as ten or twelve bits
// - ten-bit conversion uses fewer conversion clocks
// - conversion clock divided from oscillator by field
// - divide field zero clocks converter directly
// - state machines run on the oscillator clock
// - wait stabilization delay after drivers turn on
// - drivers-only command; host converts after settling
// - mode one: touch starts sequence by itself
// - mode two: host starts, device sequences
// - results are unsigned straight binary codes
// - two control registers steer the converter
// - result stored in its channel result register
// - config zero reads 4000h, writes zero
// - multiplexer routes panel or aux to converter
// - pressure uses x sample and two cross samples
// - triplet per axis: two positions, one current
// - data-available irq after conversion completes
// - pen-touch irq while touch detected
`ifndef TOUCH_ADC_MAP_SVH
`define TOUCH_ADC_MAP_SVH

// ==========================================
// register offsets (register index)
`define ADDR_CFG0 4'h0
`define ADDR_CMD 4'h1
`define ADDR_RES_BASE 4'h2
`define ADDR_RES_LAST 4'hA

// ==========================================
// configuration register zero layout
`define CFG0_READ_RESET 16'h4000
`define CFG0_WRITE_RESET 16'h0000
`define CFG0_IDLE_BIT 14
`define CFG0_RES12_BIT 13
`define CFG0_CLKDIV_LSB 11
`define CFG0_STAB_LSB 8
`define CFG0_MODE_LSB 6
`define CFG0_FUNC_LSB 2
`define CFG0_PINT_BIT 1

// ==========================================
// command codes written to the command register
`define CMD_DRIVERS 2'h1
`define CMD_CONVERT 2'h2
`define CMD_STOP 2'h3

// ==========================================
// touch modes
`define MODE_SELF 2'h1
`define MODE_HOST_INIT 2'h2
`define MODE_HOST_CTRL 2'h3

// ==========================================
// counts in oscillator cycles, channel numbers and result msb positions
`define SAMPLE_CYCLES 3'h4
`define STAB_FILL 5'h1F
`define LAST_SCAN_CHAN 4'h7
`define AUX_CHAN 4'h8
`define MSB_12 4'hB
`define MSB_10 4'h9

`endif

// [touch_adc_pkg.sv]
// types shared by the touch adc control block and its clock divider
// assumes the map header for field positions
package touch_adc_pkg;

	// ==========================================
	// conversion sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_STAB = 5'h02,
		ST_SAMPLE = 5'h04,
		ST_CONV = 5'h08,
		ST_STORE = 5'h10
	} conv_state_t;

	// ==========================================
	// divider state
	typedef struct packed {
		logic [2:0] cnt;
	} div_state_t;

	// ==========================================
	// whole state of the control block
	typedef struct packed {
		conv_state_t state;
		logic [15:0] cfg0;
		logic [11:0] sar;
		logic [3:0] bit_idx;
		logic [3:0] chan;
		logic scan_all;
		logic [7:0] stab_cnt;
		logic [2:0] samp_cnt;
		logic hold_drv;
		logic drv;
		logic shold;
		logic avail;
		logic pen_irq;
		logic pin;
		logic [15:0] rd_data;
		logic [8:0][11:0] res;
	} ctrl_state_t;

endpackage

// [conv_clock_divider.sv]
// conversion clock divider: one-cycle tick every 1, 2, 4 or 8 oscillator cycles
// assumes restart is pulsed when a conversion begins
`timescale 1ns/100ps
`include "touch_adc_map.svh"

module conv_clock_divider (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// control
	input wire logic [1:0] divide,
	input wire logic restart,
	// conversion clock tick
	output logic tick
);
	import touch_adc_pkg::*;

	touch_adc_pkg::div_state_t d_r; // counter state
	touch_adc_pkg::div_state_t d_nxt; // next counter state
	logic [2:0] limit; // last count of one period

	// period is two to the power of the divide field
	always_comb begin
		limit = 3'((4'h1 << divide) - 4'h1);
		// at or past the limit, so a lowered divide setting ticks at once
		tick = (d_r.cnt >= limit);
		d_nxt = d_r;
		if (restart || tick) begin
			d_nxt.cnt = 3'h0;
		end else begin
			d_nxt.cnt = d_r.cnt + 3'h1;
		end
	end

	// register the counter
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			d_r <= '0;
		end else begin
			d_r <= d_nxt;
		end
	end

endmodule

// [panel_front_model.sv]
// behavioural analog front end: sample-and-hold and comparator for the sar loop
// assumes levels are given in converter codes of the selected resolution
`timescale 1ns/100ps

module panel_front_model (
	// clock
	input wire logic sys_clk,
	// converter side
	input wire logic [3:0] mux_sel,
	input wire logic sample_hold,
	input wire logic [11:0] sar_code,
	output logic cmp_high,
	// panel and aux levels, one per channel
	input wire logic [8:0][11:0] level
);
	// ==========================================
	// sample and hold
	logic [11:0] held_r = 12'h000; // value held for the conversion

	// track the selected channel while sampling, hold afterwards
	always_ff @(posedge sys_clk) begin
		if (sample_hold) begin
			held_r <= level[mux_sel];
		end
	end

	// comparator: straight binary, high when input at or above trial code
	assign cmp_high = (held_r >= sar_code);
endmodule

// [touch_adc_conversion_control_bench.sv]
// self-checking bench of the touch adc conversion control block
// assumes the front end model and a 40 mhz oscillator clock
`timescale 1ns/100ps
`include "touch_adc_map.svh"

module touch_adc_conversion_control_bench;
	// ==========================================
	// stimulus and observed signals
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic reg_wr_en = 1'b0;
	logic reg_rd_en = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wr_data = 16'h0000;
	logic pen_touch_in = 1'b0;
	logic [15:0] reg_rd_data;
	logic cmp_high;
	logic [3:0] mux_sel;
	logic drivers_on;
	logic sample_hold;
	logic [11:0] sar_code;
	logic result_available;
	logic pen_touch_irq;
	logic irq_pin;
	logic [8:0][11:0] level = '0; // analog levels per channel
	int n_errors = 0;
	int n_checks = 0;
	logic [31:0] seed = 32'h22822583; // xorshift state
	logic [15:0] rd_v; // last read value
	int lat; // measured cycles to result

	// ==========================================
	// design and front end model
	touch_adc_conversion_control i_dut (.sys_clk(sys_clk), .reset(reset),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .pen_touch_in(pen_touch_in),
		.cmp_high(cmp_high), .mux_sel(mux_sel), .drivers_on(drivers_on),
		.sample_hold(sample_hold), .sar_code(sar_code), .result_available(result_available),
		.pen_touch_irq(pen_touch_irq), .touch_or_result_irq_pin(irq_pin));
	panel_front_model i_front (.sys_clk(sys_clk), .mux_sel(mux_sel),
		.sample_hold(sample_hold), .sar_code(sar_code), .cmp_high(cmp_high), .level(level));

	// clock generator, 25 ns period
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end

	// ==========================================
	// model helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// cfg0 image from its fields
	function automatic logic [15:0] cfg(int r12, int dv, int st, int md, int fn, int pi);
		return 16'((r12 << `CFG0_RES12_BIT) | (dv << `CFG0_CLKDIV_LSB) |
			(st << `CFG0_STAB_LSB) | (md << `CFG0_MODE_LSB) | (fn << `CFG0_FUNC_LSB) |
			(pi << `CFG0_PINT_BIT));
	endfunction

	// expected cycles from command edge to result flag
	function automatic int exp_lat(int stab_on, int st, int r12, int dv);
		// settle, four sampling cycles, one tick per bit, then one store cycle
		return (stab_on ? st * 32 + 32 : 0) + 5 + ((r12 ? 12 : 10) << dv);
	endfunction

	// fresh random levels within the resolution
	task automatic new_levels(int r12);
		for (int i = 0; i < 9; i++) begin
			level[i] = 12'(xs()) & (r12 ? 12'hFFF : 12'h3FF);
		end
	endtask

	// ==========================================
	// bus tasks and compare
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge sys_clk);
		#2 reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wr_data = d;
		@(posedge sys_clk);
		#2 reg_wr_en = 1'b0;
	endtask

	task automatic rd(logic [3:0] a);
		@(posedge sys_clk);
		#2 reg_rd_en = 1'b1;
		reg_addr = a;
		@(posedge sys_clk);
		#2 reg_rd_en = 1'b0;
		rd_v = reg_rd_data;
	endtask

	// command then count edges until the result flag rises
	task automatic run_conv();
		wr(`ADDR_CMD, 16'(`CMD_CONVERT));
		lat = 0;
		while (lat < 3000 && result_available !== 1'b1) begin
			@(posedge sys_clk);
			#1 lat++;
		end
	endtask

	// verdict and end of run
	task automatic results();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// watchdog well beyond the expected run
	initial begin
		#(25 * 60000);
		n_errors++;
		results();
	end

	// ==========================================
	// main sequence
	initial begin
		int dv[6] = '{0, 1, 1, 2, 0, 1}; // divide settings per pass
		int rr[6] = '{0, 0, 1, 1, 0, 1}; // twelve-bit flags per pass
		int ch;
		int md; // touch mode per pass, zero acts as host control
		repeat (2) @(posedge sys_clk);
		#2 reset = 1'b0;
		// reset values and unmapped index
		rd(`ADDR_CFG0);
		check("cfg0 reset", rd_v, 16'h4000);
		rd(4'hF);
		check("unmapped", rd_v, 16'h0000);
		$display("test reset done");
		// host controlled conversions over resolutions and dividers
		for (int i = 0; i < 6; i++) begin
			ch = (i * 5) % 9;
			md = (i == 4) ? 0 : 3;
			new_levels(rr[i]);
			wr(`ADDR_CFG0, cfg(rr[i], dv[i], 0, md, ch + 1, 1));
			rd(`ADDR_CFG0);
			check("cfg0 back", rd_v, cfg(rr[i], dv[i], 0, md, ch + 1, 1) | 16'h4000);
			run_conv();
			check("latency", lat, exp_lat(0, 0, rr[i], dv[i]));
			check("pin avail", irq_pin, 1'b1);
			rd(4'(`ADDR_RES_BASE + ch));
			check("result", rd_v, {4'h0, level[ch]});
			check("avail clr", result_available, 1'b0);
		end
		$display("test host conversions done");
		// drivers only command, then stop
		wr(`ADDR_CMD, 16'(`CMD_DRIVERS));
		repeat (3) @(posedge sys_clk);
		check("drivers held", drivers_on, 1'b1);
		check("no result", result_available, 1'b0);
		rd(`ADDR_CMD);
		check("hold bit", rd_v & 16'h0002, 16'h0002);
		wr(`ADDR_CMD, 16'(`CMD_STOP));
		repeat (2) @(posedge sys_clk);
		check("drivers off", drivers_on, 1'b0);
		$display("test drivers done");
		// host initiated, device sequenced with stabilization, aux input
		new_levels(1);
		wr(`ADDR_CFG0, cfg(1, 2, 1, 2, 10, 0));
		run_conv();
		check("stab latency", lat, exp_lat(1, 1, 1, 2));
		rd(`ADDR_RES_LAST);
		check("aux result", rd_v, {4'h0, level[8]});
		$display("test host initiated done");
		// self initiated scan of all panel channels on touch
		new_levels(0);
		wr(`ADDR_CFG0, cfg(0, 0, 0, 1, 0, 0));
		@(posedge sys_clk);
		#2 pen_touch_in = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1 check("pen irq", pen_touch_irq, 1'b1);
		check("pin pen", irq_pin, 1'b1);
		repeat (8) @(posedge sys_clk);
		#2 pen_touch_in = 1'b0;
		check("scan drivers", drivers_on, 1'b1);
		rd_v = 16'h0001;
		for (int k = 0; k < 400 && rd_v[0] !== 1'b0; k++) begin
			repeat (4) @(posedge sys_clk);
			rd(`ADDR_CMD);
		end
		check("scan idle", rd_v[0], 1'b0);
		for (int c = 0; c < 8; c++) begin
			rd(4'(`ADDR_RES_BASE + c));
			check("scan result", rd_v, {4'h0, level[c]});
		end
		$display("test touch scan done");
		results();
	end
endmodule
